// ===== rtl/can_mode_defines.svh
/*
 Named offsets, codes, field positions and timing counts of the CAN
 transceiver mode controller. Assumes inclusion by bare name only.
*/
`ifndef CAN_MODE_DEFINES_SVH
`define CAN_MODE_DEFINES_SVH
`define ADDR_CTRL 8'h00
`define ADDR_STATE 8'h04
`define ADDR_KIND 8'h08
`define ADDR_TXFMT 8'h0c
`define ADDR_FDSTD 8'h10
`define ADDR_BAUD 8'h14
`define ADDR_STATUS 8'h18
`define CTRL_START 0
`define TS_NORMAL 2'h0
`define TS_SLEEP 2'h1
`define TS_SWWAKE 2'h2
`define TS_SWHS 2'h3
`define KIND_HS 3'h0
`define KIND_LS 3'h1
`define KIND_SW 3'h2
`define KIND_EXT 3'h3
`define KIND_DISC 3'h4
`define CM_CLASSIC 2'h0
`define CM_FD 2'h1
`define CM_FDBRS 2'h2
`define FD_ISO 2'h0
`define FD_NONISO 2'h1
`define FD_LEGACY 2'h2
`define BAUD_HS_MIN 32'd40000
`define BAUD_HS_MAX 32'd1000000
`define BAUD_LS_MIN 32'd40000
`define BAUD_LS_MAX 32'd125000
`define BAUD_SW_LO 32'd33333
`define BAUD_SW_HI 32'd83333
`define BAUD_RESET 32'd500000
`define ST_ERR_STATE 0
`define ST_ERR_KIND 1
`define ST_ERR_FMT 2
`define ST_ERR_STD 3
`define ST_WAKE 4
`define ST_BAUD_BAD 5
`define ST_ASLEEP 6
`define ST_DRAIN 7
`define CLK_PERIOD_NS 10
`define BUS_IDLE_NS 330000
`endif

// ===== rtl/can_mode_pkg.sv
/*
 Types shared by the CAN transceiver mode controller modules.
 Assumes the defines header supplies all numeric codes except the sleep state encoding.
*/
package can_mode_pkg;
   typedef enum logic [3:0] {
      SLP_AWAKE = 4'b0001,
      SLP_DRAIN = 4'b0010,
      SLP_ASLEEP = 4'b0100,
      SLP_WAKEFRAME = 4'b1000
   } sleep_state_e;
   typedef logic [1:0] tstate_t;
   typedef logic [2:0] kind_t;
   typedef logic [1:0] cmode_t;
   typedef logic [1:0] fdstd_t;
endpackage

// ===== rtl/sleep_if.sv
/*
 Carrier between the register block, the sleep sequencer and the bus
 watcher. Assumes all parties share core_clk.
*/
`timescale 1ns/1ps
interface sleep_if;
   logic sleepReq;
   logic wakeReq;
   logic txPending;
   logic busDominant;
   logic busIdle;
   logic asleep;
   logic draining;
   logic remoteWake;
   modport ctrl(output sleepReq, wakeReq, txPending,
      input asleep, draining, remoteWake);
   modport fsm(input sleepReq, wakeReq, txPending, busDominant, busIdle,
      output asleep, draining, remoteWake);
   modport watch(output busDominant, busIdle);
endinterface

// ===== rtl/can_bus_watch.sv
/*
 Synchronises the receive pin and reports a dominant bus and an idle
 bus (recessive for IDLE_CYCLES). Assumes canRx is asynchronous.
*/
`timescale 1ns/1ps
module can_bus_watch #(
   parameter int unsigned IDLE_CYCLES = 33000
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // pin
   input wire logic canRx,
   // toward sequencer
   sleep_if.watch bus
);
   logic rxMeta_reg;
   logic rxSync_reg;
   logic [15:0] idleCnt_reg;
   logic idle_reg;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rxMeta_reg <= 1'b1;
         rxSync_reg <= 1'b1;
      end else begin
         rxMeta_reg <= canRx;
         rxSync_reg <= rxMeta_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         idleCnt_reg <= 16'h0000;
         idle_reg <= 1'b0;
      end else if (!rxSync_reg) begin
         idleCnt_reg <= 16'h0000;
         idle_reg <= 1'b0;
      end else if (idleCnt_reg == 16'(IDLE_CYCLES - 1)) begin
         idle_reg <= 1'b1;
      end else begin
         idleCnt_reg <= idleCnt_reg + 16'h0001;
      end
   end

   assign bus.busDominant = ~rxSync_reg;
   assign bus.busIdle = idle_reg;
endmodule

// ===== rtl/can_sleep_fsm.sv
/*
 Sleep sequencer: drains pending frames, sleeps, and wakes locally or
 on a remote wakeup frame followed by an idle bus.
 Assumes requests are single-cycle pulses from the register block.
*/
`timescale 1ns/1ps
module can_sleep_fsm
   import can_mode_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // control and bus view
   sleep_if.fsm sl
);
   sleep_state_e state_reg;
   logic wake_reg;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= SLP_AWAKE;
      end else begin
         case (state_reg)
            SLP_AWAKE: if (sl.sleepReq) state_reg <= SLP_DRAIN;
            SLP_DRAIN: begin
               if (sl.wakeReq) state_reg <= SLP_AWAKE;
               else if (!sl.txPending) state_reg <= SLP_ASLEEP;
            end
            SLP_ASLEEP: begin
               if (sl.wakeReq) state_reg <= SLP_AWAKE;
               else if (sl.busDominant) state_reg <= SLP_WAKEFRAME;
            end
            SLP_WAKEFRAME: begin
               if (sl.wakeReq) state_reg <= SLP_AWAKE;
               else if (sl.busIdle) state_reg <= SLP_AWAKE;
            end
            default: state_reg <= SLP_AWAKE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) wake_reg <= 1'b0;
      else wake_reg <= (state_reg == SLP_WAKEFRAME) && !sl.wakeReq &&
         sl.busIdle;
   end

   // frames stay queued in the controller, so transmission resumes where
   // it stopped
   assign sl.asleep = (state_reg == SLP_ASLEEP) ||
      (state_reg == SLP_WAKEFRAME);
   assign sl.draining = (state_reg == SLP_DRAIN);
   assign sl.remoteWake = wake_reg;
endmodule

// ===== rtl/can_transceiver_mode_control.sv
/*
 CAN transceiver mode control: transceiver kind, sleep and wakeup
 sequencing, single-wire wakeup voltage and high-speed, transmit frame
 format and FD standard selection, with an AHB-Lite register slave.
 Assumes a single master, one clock, and a CAN controller that keeps its
 transmit queue while held asleep.
// What this block does
// - state codes 0..3, default normal
// - normal or wakeup write wakes sleeper
// - sleep refused unless port started
// - drain pending frames, then standby
// - remote frame wakes, not received, unacknowledged
// - wakeup frame then idle gives normal
// - transmission resumes where it stopped
// - single-wire wakeup drives high voltage
// - wakeup refused if not single-wire or high-speed
// - high-speed state disables waveshaping
// - high-speed needs single-wire; no sleep from it
// - kind codes 0..4, readable
// - kind changes only when stopped; default
// - bit rate ranges checked per kind
// - disconnect isolates controller from connector
// - tx format defaults cluster, never exceeds
// - tx format affects transmit only
// - ISO mode: frame type field selects
// - FD standard ISO default, choose variant
// - ISO reports received type, else generic
// - legacy: ISO framing, non-ISO host view
*/
`timescale 1ns/1ps
`include "can_mode_defines.svh"
module can_transceiver_mode_control
   import can_mode_pkg::*;
#(
   parameter int unsigned IDLE_CYCLES = `BUS_IDLE_NS / `CLK_PERIOD_NS,
   parameter logic SELECTABLE = 1'b1,
   parameter logic [2:0] FIXED_KIND = 3'h0
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // CAN controller side
   input wire logic txPending,
   input wire logic [1:0] frameTxType,
   output logic ctrlSleep,
   output logic rxAckBlock,
   output logic txEnable,
   output logic [1:0] txFormat,
   output logic rxFdEnable,
   output logic fdIsoFraming,
   output logic rxTypeReport,
   // transceiver side
   input wire logic canRx,
   output logic [2:0] tcvrKind,
   output logic hsEnable,
   output logic lsEnable,
   output logic swEnable,
   output logic extEnable,
   output logic connectorLink,
   output logic tcvrStandby,
   output logic swWakeVoltage,
   output logic swWaveshapeOff
);
   sleep_if sl();

   can_bus_watch #(.IDLE_CYCLES(IDLE_CYCLES)) u_watch (
      .core_clk(core_clk),
      .rstn(rstn),
      .canRx(canRx),
      .bus(sl)
   );

   can_sleep_fsm u_fsm (
      .core_clk(core_clk),
      .rstn(rstn),
      .sl(sl)
   );

   // bus address phase capture
   logic wrPend_reg;
   logic [7:0] wrAddr_reg;
   logic addrTake;
   logic [31:0] rdValue;

   // registers
   logic started_reg;
   cmode_t cluster_reg;
   tstate_t tstate_reg, tstate_next;
   kind_t kind_reg, kind_next;
   cmode_t txFmt_reg;
   logic txFmtSet_reg;
   fdstd_t fdStd_reg;
   logic [31:0] baud_reg;
   logic [4:0] sticky_reg;
   logic [4:0] errSet;

   // decoded write strobes and request checks
   logic wrCtrl, wrState, wrKind, wrTxFmt, wrFdStd, wrBaud, wrStatus;
   logic stateErr, kindErr, fmtErr, stdErr;
   logic wakeLocal, sleepGo, clusterFd, baudBad;
   cmode_t txSel;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addrTake = hsel && htrans[1] && hready;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wrPend_reg <= 1'b0;
         wrAddr_reg <= 8'h00;
      end else begin
         wrPend_reg <= addrTake && hwrite;
         if (addrTake) wrAddr_reg <= haddr[7:0];
      end
   end

   always_comb begin
      {wrCtrl, wrState, wrKind, wrTxFmt, wrFdStd, wrBaud, wrStatus} = 7'h00;
      if (!wrPend_reg) wrCtrl = 1'b0;
      else if (wrAddr_reg == `ADDR_CTRL) wrCtrl = 1'b1;
      else if (wrAddr_reg == `ADDR_STATE) wrState = 1'b1;
      else if (wrAddr_reg == `ADDR_KIND) wrKind = 1'b1;
      else if (wrAddr_reg == `ADDR_TXFMT) wrTxFmt = 1'b1;
      else if (wrAddr_reg == `ADDR_FDSTD) wrFdStd = 1'b1;
      else if (wrAddr_reg == `ADDR_BAUD) wrBaud = 1'b1;
      else if (wrAddr_reg == `ADDR_STATUS) wrStatus = 1'b1;
   end

   assign clusterFd = (cluster_reg != `CM_CLASSIC);

   // transceiver state request checks
   always_comb begin
      tstate_next = tstate_reg;
      {stateErr, wakeLocal, sleepGo} = 3'b000;
      if (wrState) begin
         case (hwdata[1:0])
            `TS_NORMAL: begin
               tstate_next = `TS_NORMAL;
               wakeLocal = sl.asleep || sl.draining;
            end
            `TS_SLEEP: begin
               if (!started_reg) stateErr = 1'b1;
               else if (tstate_reg == `TS_SWHS) stateErr = 1'b1;
               else begin
                  tstate_next = `TS_SLEEP;
                  sleepGo = !sl.asleep && !sl.draining;
               end
            end
            `TS_SWWAKE: begin
               if (kind_reg != `KIND_SW) stateErr = 1'b1;
               else if (tstate_reg == `TS_SWHS) stateErr = 1'b1;
               else begin
                  tstate_next = `TS_SWWAKE;
                  wakeLocal = sl.asleep || sl.draining;
               end
            end
            default: begin
               if (kind_reg != `KIND_SW) stateErr = 1'b1;
               else begin
                  tstate_next = `TS_SWHS;
                  wakeLocal = sl.asleep || sl.draining;
               end
            end
         endcase
         if (hwdata[31:2] != 30'h00000000) begin
            tstate_next = tstate_reg;
            {stateErr, wakeLocal, sleepGo} = 3'b100;
         end
      end else if (sl.remoteWake) begin
         tstate_next = `TS_NORMAL;
      end else if (wrCtrl && !hwdata[`CTRL_START]) begin
         tstate_next = `TS_NORMAL;
         wakeLocal = sl.asleep || sl.draining;
      end
   end

   assign sl.sleepReq = sleepGo;
   assign sl.wakeReq = wakeLocal;
   assign sl.txPending = txPending;

   // kind request checks
   always_comb begin
      kind_next = kind_reg;
      kindErr = 1'b0;
      if (wrKind) begin
         if (started_reg) kindErr = 1'b1;
         else if (hwdata > 32'(`KIND_DISC)) kindErr = 1'b1;
         else if (!SELECTABLE && hwdata[2:0] != FIXED_KIND) kindErr = 1'b1;
         else kind_next = hwdata[2:0];
      end
   end

   // transmit format and standard checks
   always_comb begin
      fmtErr = 1'b0;
      stdErr = 1'b0;
      if (wrTxFmt) begin
         if (clusterFd && fdStd_reg == `FD_ISO) fmtErr = 1'b1;
         else if (hwdata > 32'(cluster_reg)) fmtErr = 1'b1;
      end
      if (wrFdStd && hwdata > 32'(`FD_LEGACY)) stdErr = 1'b1;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         started_reg <= 1'b0;
         cluster_reg <= `CM_CLASSIC;
      end else if (wrCtrl) begin
         started_reg <= hwdata[`CTRL_START];
         cluster_reg <= (hwdata[2:1] > `CM_FDBRS) ? `CM_FDBRS : hwdata[2:1];
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) tstate_reg <= `TS_NORMAL;
      else if (wrKind && !kindErr) tstate_reg <= `TS_NORMAL;
      else tstate_reg <= tstate_next;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) kind_reg <= SELECTABLE ? `KIND_HS : FIXED_KIND;
      else if (!SELECTABLE) kind_reg <= FIXED_KIND;
      else kind_reg <= kind_next;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         txFmt_reg <= `CM_CLASSIC;
         txFmtSet_reg <= 1'b0;
      end else if (wrCtrl) begin
         txFmtSet_reg <= 1'b0;
      end else if (wrTxFmt && !fmtErr) begin
         txFmt_reg <= hwdata[1:0];
         txFmtSet_reg <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) fdStd_reg <= `FD_ISO;
      else if (wrFdStd && !stdErr) fdStd_reg <= hwdata[1:0];
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) baud_reg <= `BAUD_RESET;
      else if (wrBaud) baud_reg <= hwdata;
   end

   // rate legality per kind
   always_comb begin
      case (kind_reg)
         `KIND_HS: baudBad = baud_reg < `BAUD_HS_MIN ||
            baud_reg > `BAUD_HS_MAX;
         `KIND_LS: baudBad = baud_reg < `BAUD_LS_MIN ||
            baud_reg > `BAUD_LS_MAX;
         `KIND_SW: baudBad = baud_reg != `BAUD_SW_LO &&
            baud_reg != `BAUD_SW_HI;
         default: baudBad = 1'b0;
      endcase
   end

   // sticky flags: a new event wins over a write-one clear
   assign errSet = {sl.remoteWake, stdErr, fmtErr, kindErr, stateErr};

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) sticky_reg <= 5'h00;
      else if (wrStatus) sticky_reg <= (sticky_reg & ~hwdata[4:0]) | errSet;
      else sticky_reg <= sticky_reg | errSet;
   end

   // read mux registered in the address phase
   always_comb begin
      rdValue = 32'h00000000;
      if (haddr[7:0] == `ADDR_CTRL)
         rdValue = {29'h00000000, cluster_reg, started_reg};
      else if (haddr[7:0] == `ADDR_STATE)
         rdValue = {30'h00000000, tstate_reg};
      else if (haddr[7:0] == `ADDR_KIND)
         rdValue = {29'h00000000, kind_reg};
      else if (haddr[7:0] == `ADDR_TXFMT)
         rdValue = {30'h00000000, txFmtSet_reg ? txFmt_reg : cluster_reg};
      else if (haddr[7:0] == `ADDR_FDSTD)
         rdValue = {30'h00000000, fdStd_reg};
      else if (haddr[7:0] == `ADDR_BAUD)
         rdValue = baud_reg;
      else if (haddr[7:0] == `ADDR_STATUS)
         rdValue = {24'h000000, sl.draining, sl.asleep, baudBad, sticky_reg};
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) hrdata <= 32'h00000000;
      else if (addrTake && !hwrite) hrdata <= rdValue;
   end

   // ISO mode takes the per-frame type; otherwise the setting, never
   // above the cluster mode
   always_comb begin
      if (clusterFd && fdStd_reg == `FD_ISO) txSel = frameTxType;
      else if (txFmtSet_reg) txSel = txFmt_reg;
      else txSel = cluster_reg;
      if (txSel > cluster_reg) txSel = cluster_reg;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         txFormat <= `CM_CLASSIC;
         {rxFdEnable, fdIsoFraming, rxTypeReport} <= 3'b000;
      end else begin
         txFormat <= txSel;
         rxFdEnable <= clusterFd;
         fdIsoFraming <= clusterFd && fdStd_reg != `FD_NONISO;
         rxTypeReport <= clusterFd && fdStd_reg == `FD_ISO;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tcvrKind <= `KIND_HS;
         {hsEnable, lsEnable, swEnable, extEnable, connectorLink} <= 5'h00;
      end else begin
         tcvrKind <= kind_reg;
         hsEnable <= kind_reg == `KIND_HS;
         lsEnable <= kind_reg == `KIND_LS;
         swEnable <= kind_reg == `KIND_SW;
         extEnable <= kind_reg == `KIND_EXT;
         connectorLink <= kind_reg != `KIND_DISC;
      end
   end

   // the wakeup voltage lasts exactly as long as the state is held, so
   // software owns its duration
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         {tcvrStandby, ctrlSleep, rxAckBlock, txEnable} <= 4'h0;
         {swWakeVoltage, swWaveshapeOff} <= 2'b00;
      end else begin
         tcvrStandby <= sl.asleep;
         ctrlSleep <= sl.asleep;
         rxAckBlock <= sl.asleep;
         txEnable <= started_reg && !sl.asleep;
         swWakeVoltage <= tstate_reg == `TS_SWWAKE &&
            kind_reg == `KIND_SW;
         swWaveshapeOff <= tstate_reg == `TS_SWHS &&
            kind_reg == `KIND_SW;
      end
   end
endmodule

// ===== tb/can_mode_checker.sv
/*
 Concurrent checks on the mode controller's ports.
 Assumes the bind below and the controller's IDLE_CYCLES setting.
*/
`timescale 1ns/1ps
module can_mode_checker #(
   parameter int unsigned IDLE_CYCLES = 33000
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hreadyout,
   input wire logic hresp,
   // controller and transceiver
   input wire logic canRx,
   input wire logic ctrlSleep,
   input wire logic rxAckBlock,
   input wire logic tcvrStandby,
   input wire logic txEnable,
   input wire logic [1:0] txFormat,
   input wire logic rxFdEnable,
   input wire logic fdIsoFraming,
   input wire logic rxTypeReport,
   input wire logic [2:0] tcvrKind,
   input wire logic hsEnable,
   input wire logic swEnable,
   input wire logic connectorLink,
   input wire logic swWakeVoltage,
   input wire logic swWaveshapeOff
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   int unsigned quietCnt;
   logic [7:0] busHist;
   // raw pin run; the sync flops only make the design's run shorter
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         quietCnt <= 0;
      end else begin
         quietCnt <= canRx ? quietCnt + 1 : 0;
      end
   end
   // a software write may wake at once, so recent transfers excuse it
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         busHist <= 8'h00;
      end else begin
         busHist <= {busHist[6:0], hsel & htrans[1]};
      end
   end
   sequence s_held_asleep;
      ctrlSleep [*2];
   endsequence
   sequence s_fd_iso;
      rxFdEnable && fdIsoFraming;
   endsequence
   a_bus_okay: assert property (hsel && htrans[1] |-> hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   a_sleep_group: assert property (ctrlSleep == tcvrStandby &&
      ctrlSleep == rxAckBlock)
      else $error("sleep outputs disagree");
   a_asleep_notx: assert property (s_held_asleep |-> !txEnable)
      else $error("transmit enabled while asleep");
   a_kind_onehot: assert property ($past(rstn) |->
      hsEnable == (tcvrKind == 3'h0) && swEnable == (tcvrKind == 3'h2))
      else $error("kind enables do not match kind");
   a_disc_isolates: assert property ($past(rstn) |->
      connectorLink == (tcvrKind != 3'h4))
      else $error("connector link wrong for kind");
   a_wake_volt: assert property (swWakeVoltage |->
      swEnable && !ctrlSleep)
      else $error("wakeup voltage without single-wire");
   a_waveshape_kind: assert property (swWaveshapeOff |->
      swEnable && !swWakeVoltage && !ctrlSleep)
      else $error("waveshaping off in wrong mode");
   a_fd_report: assert property (rxTypeReport |-> s_fd_iso)
      else $error("type report outside ISO FD");
   a_txfmt_classic: assert property (!rxFdEnable |->
      txFormat == 2'h0)
      else $error("transmit format above classic cluster");
   a_idle_wake: assert property ($fell(ctrlSleep) &&
      busHist == 8'h00 |-> quietCnt >= IDLE_CYCLES)
      else $error("remote wake before idle bus");
endmodule

bind can_transceiver_mode_control can_mode_checker #(
   .IDLE_CYCLES(IDLE_CYCLES)
) checker_i (
   .core_clk, .rstn, .hsel, .htrans, .hreadyout, .hresp, .canRx,
   .ctrlSleep, .rxAckBlock, .tcvrStandby, .txEnable, .txFormat,
   .rxFdEnable, .fdIsoFraming, .rxTypeReport, .tcvrKind, .hsEnable,
   .swEnable, .connectorLink, .swWakeVoltage, .swWaveshapeOff
);

// ===== tb/can_node_model.sv
/*
 Remote CAN node: sends one short wakeup frame on request.
 Assumes the pin rests recessive (high) between frames.
*/
`timescale 1ns/1ps
module can_node_model (
   // clock
   input wire logic core_clk,
   // stimulus
   input wire logic sendFrame,
   // bus pin
   output logic canRx
);
   localparam logic [11:0] FRAME = 12'h0c3;
   initial canRx = 1'b1;
   always @(posedge core_clk) begin
      if (sendFrame) begin
         for (int i = 11; i >= 0; i--) begin
            canRx <= FRAME[i];
            @(posedge core_clk);
         end
         canRx <= 1'b1;
      end
   end
endmodule

// ===== tb/can_transceiver_mode_control_test.sv
/*
 Self-checking bench: AHB-Lite master tasks, register rows, then
 sleep, wake, FD and reset cases. Assumes the node model on canRx.
*/
`timescale 1ns/1ps
`include "can_mode_defines.svh"
module can_transceiver_mode_control_test;
   typedef struct packed {
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } row_s;
   logic core_clk = 0, rstn = 0, hsel = 0, hwrite = 0, txPending = 0;
   logic sendFrame = 0, hreadyout, hresp, ctrlSleep, rxAckBlock, txEnable;
   logic rxFdEnable, fdIsoFraming, rxTypeReport, canRx, hsEnable, lsEnable;
   logic swEnable, extEnable, connectorLink, tcvrStandby, swWakeVoltage;
   logic swWaveshapeOff;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0] htrans = 0, frameTxType = 0, txFormat;
   logic [2:0] hsize = 3'h2, tcvrKind;
   int errCount = 0, checks = 0;
   row_s rows [14] = '{
      {`ADDR_STATE, 32'h2, 32'h0}, {`ADDR_STATE, 32'h3, 32'h0},
      {`ADDR_STATE, 32'h1, 32'h0}, {`ADDR_STATE, 32'h4, 32'h0},
      {`ADDR_KIND, 32'h5, 32'h0}, {`ADDR_KIND, 32'h1, 32'h1},
      {`ADDR_KIND, 32'h3, 32'h3}, {`ADDR_KIND, 32'h2, 32'h2},
      {`ADDR_STATE, 32'h3, 32'h3}, {`ADDR_STATE, 32'h2, 32'h3},
      {`ADDR_STATE, 32'h1, 32'h3}, {`ADDR_STATE, 32'h0, 32'h0},
      {`ADDR_FDSTD, 32'h3, 32'h0}, {`ADDR_BAUD, 32'd83333, 32'd83333}};
   always #5 core_clk = ~core_clk;
   can_transceiver_mode_control #(.IDLE_CYCLES(20)) dut (
      .core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .txPending,
      .frameTxType, .ctrlSleep, .rxAckBlock, .txEnable, .txFormat,
      .rxFdEnable, .fdIsoFraming, .rxTypeReport, .canRx, .tcvrKind,
      .hsEnable, .lsEnable, .swEnable, .extEnable, .connectorLink,
      .tcvrStandby, .swWakeVoltage, .swWaveshapeOff);
   can_node_model node (.core_clk, .sendFrame, .canRx);
   task automatic printVerdict;
      $display("checks %0d errors %0d", checks, errCount);
      if (errCount == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, got);
      checks++;
      if (got !== exp) begin
         errCount++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // every wait is bounded; a stuck slave ends the run
   task automatic waitRdy;
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         errCount++;
         printVerdict();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      waitRdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitRdy();
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a,
      input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic waitSleep(input logic v);
      int n;
      n = 0;
      while (ctrlSleep !== v && n < 200) begin
         @(posedge core_clk);
         n++;
      end
      chk("ctrlSleep", v, ctrlSleep);
      if (ctrlSleep !== v)
         printVerdict();
   endtask
   initial begin
      tick(20);
      rstn <= 1'b1;
      tick(1);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rdc($sformatf("row%0d", i), rows[i].a, rows[i].e);
         chk("lsEnable", i == 5, lsEnable);
         chk("extEnable", i == 6, extEnable);
      end
      tick(1);
      chk("swEnable", 1, swEnable);
      wr(`ADDR_KIND, 32'h4);
      tick(2);
      chk("connectorLink", 0, connectorLink);
      wr(`ADDR_KIND, 32'h2);
      wr(`ADDR_CTRL, 32'h1);
      txPending <= 1'b1;
      wr(`ADDR_STATE, 32'h1);
      tick(3);
      chk("ctrlSleep", 0, ctrlSleep);
      bus(1'b0, `ADDR_STATUS, 32'h0);
      chk("draining", 1, rd[`ST_DRAIN]);
      wr(`ADDR_KIND, 32'h0);
      rdc("kind", `ADDR_KIND, 32'h2);
      txPending <= 1'b0;
      waitSleep(1'b1);
      chk("txEnable", 0, txEnable);
      chk("tcvrStandby", 1, tcvrStandby);
      wr(`ADDR_STATE, 32'h2);
      tick(2);
      chk("ctrlSleep", 0, ctrlSleep);
      chk("swWakeVoltage", 1, swWakeVoltage);
      chk("txEnable", 1, txEnable);
      wr(`ADDR_STATE, 32'h0);
      wr(`ADDR_STATE, 32'h1);
      waitSleep(1'b1);
      sendFrame <= 1'b1;
      tick(1);
      sendFrame <= 1'b0;
      tick(6);
      chk("rxAckBlock", 1, rxAckBlock);
      waitSleep(1'b0);
      rdc("state", `ADDR_STATE, 32'h0);
      bus(1'b0, `ADDR_STATUS, 32'h0);
      chk("wakeSeen", 1, rd[`ST_WAKE]);
      wr(`ADDR_STATE, 32'h3);
      tick(2);
      chk("swWaveshapeOff", 1, swWaveshapeOff);
      wr(`ADDR_STATE, 32'h1);
      rdc("state", `ADDR_STATE, 32'h3);
      wr(`ADDR_STATE, 32'h0);
      wr(`ADDR_CTRL, 32'h5);
      frameTxType <= 2'h1;
      tick(3);
      chk("txFormat", 1, txFormat);
      chk("rxTypeReport", 1, rxTypeReport);
      wr(`ADDR_FDSTD, 32'h2);
      tick(2);
      chk("fdIsoFraming", 1, fdIsoFraming);
      chk("rxTypeReport", 0, rxTypeReport);
      wr(`ADDR_FDSTD, 32'h1);
      wr(`ADDR_TXFMT, 32'h0);
      wr(`ADDR_TXFMT, 32'h3);
      tick(2);
      chk("txFormat", 0, txFormat);
      chk("rxFdEnable", 1, rxFdEnable);
      chk("fdIsoFraming", 0, fdIsoFraming);
      rstn <= 1'b0;
      tick(20);
      rstn <= 1'b1;
      tick(1);
      rdc("kind", `ADDR_KIND, 32'h0);
      rdc("state", `ADDR_STATE, 32'h0);
      rdc("fdstd", `ADDR_FDSTD, 32'h0);
      rdc("baud", `ADDR_BAUD, `BAUD_RESET);
      wr(`ADDR_BAUD, `BAUD_HS_MIN - 32'd1);
      bus(1'b0, `ADDR_STATUS, 32'h0);
      chk("baudBad", 1, rd[`ST_BAUD_BAD]);
      rdc("unmapped", 8'h40, 32'h0);
      chk("hsEnable", 1, hsEnable);
      printVerdict();
   end
endmodule
